// File: fdpc_cfg.svh
// Constants of the floppy drive pin control block.
// Assumes an APB slave with 32-bit data, one aligned word per register.
`ifndef FDPC_CFG_SVH
`define FDPC_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define FDPC_OFS_DIGOUT 8'h00
`define FDPC_OFS_DSR 8'h04
`define FDPC_OFS_CFGCTL 8'h08
`define FDPC_OFS_FNEN 8'h0c
`define FDPC_OFS_FNCTL 8'h10
`define FDPC_OFS_MODE 8'h14
`define FDPC_OFS_CONF 8'h18
`define FDPC_OFS_LOCK 8'h1c
`define FDPC_OFS_SPEC 8'h20
`define FDPC_OFS_STAT 8'h24

// ------------------------------------------------------------
// Reset and default values
// ------------------------------------------------------------
`define FDPC_DIGOUT_RST 8'h00
`define FDPC_DSR_RST 8'h02
`define FDPC_CFGCTL_RST 8'h02
`define FDPC_FNEN_RST 8'h00
`define FDPC_FNCTL_RST 8'h00
`define FDPC_MODE_RST 8'h00
`define FDPC_CONF_RST 8'h00
`define FDPC_LOCK_RST 8'h00
`define FDPC_SPEC_RST 8'h00

// ------------------------------------------------------------
// Field positions, address width and pin levels
// ------------------------------------------------------------
`define FDPC_DIGOUT_EN_BIT 2
`define FDPC_DIGOUT_MOT_LSB 4
`define FDPC_DIGOUT_SEL 1:0
`define FDPC_DSR_RATE 1:0
`define FDPC_FNEN_FOUR_BIT 4
`define FDPC_FNCTL_SWAP_BIT 4
`define FDPC_FNCTL_RATE_BIT 0
`define FDPC_ADDR_W 8
`define FDPC_INACT_N 2'h3
`define FDPC_RATE_IDLE 2'h0
`define FDPC_OE_OFF 2'h0
`define FDPC_OE_ON 2'h3
`define FDPC_PULL_ON 2'h3
`define FDPC_PULL_OFF 2'h0

`endif

// File: fdpc_drive_model.sv
// Drive-side model: resolves the two media sense pins.
// Assumes the controller pins are registered levels on one clock.
`timescale 1ns/1ns
module fdpc_drive_model (
  // Controller pins
  input wire logic [1:0] motorEnableN,
  input wire logic [1:0] dataRateOut,
  input wire logic [1:0] dataRateOe,
  input wire logic [1:0] mediaPullupEn,
  // Media code from the drive; undriven bits float
  input wire logic [1:0] senseDrv,
  input wire logic [1:0] senseVal,
  // Pin level seen by the controller
  output logic [1:0] mediaSenseIn,
  output logic [1:0] motorSpin
);
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (dataRateOe[i]) begin
        mediaSenseIn[i] = dataRateOut[i];
      end else if (senseDrv[i]) begin
        mediaSenseIn[i] = senseVal[i];
      end else if (mediaPullupEn[i]) begin
        mediaSenseIn[i] = 1'b1;
      end else begin
        mediaSenseIn[i] = ~dataRateOut[i];
      end
    end
  end
  // Spindle follows the active-low enables
  assign motorSpin = ~motorEnableN;
endmodule : fdpc_drive_model

// File: fdpc_motor_enc.sv
// Motor enable encoder: plain, four-drive and swapped forms.
// Assumes the caller registers and inverts the logical result.
`timescale 1ns/1ns
module fdpc_motor_enc
  import fdpc_pkg::*;
(
  // Register side
  fdpc_motor_if.enc mot
);
  logic [1:0] plainVal;
  logic [1:0] encVal;

  // ------------------------------------------------------------
  // Encoding
  // ------------------------------------------------------------
  always_comb begin
    plainVal = mot.motorBits[1:0];
    encVal[0] = mot.motorBits[mot.driveSel];
    encVal[1] = mot.driveSel[1];
  end

  always_comb begin
    if (mot.fourDrive) begin
      mot.motorLogic = mot.swap ? {encVal[0], encVal[1]} : encVal;
    end else begin
      mot.motorLogic = mot.swap ? {plainVal[0], plainVal[1]} : plainVal;
    end
  end
endmodule : fdpc_motor_enc

// File: fdpc_motor_if.sv
// Carrier between register file and motor encoder.
// Assumes one clock domain; signals are plain levels.
`timescale 1ns/1ns
interface fdpc_motor_if;
  logic [3:0] motorBits;
  logic [1:0] driveSel;
  logic fourDrive;
  logic swap;
  logic [1:0] motorLogic;
  modport ctrl (output motorBits, driveSel, fourDrive, swap,
                input motorLogic);
  modport enc (input motorBits, driveSel, fourDrive, swap,
               output motorLogic);
endinterface : fdpc_motor_if

// File: fdpc_pin_ctrl.sv
// Floppy drive pin control: master reset, motor enables, media sense.
// Assumes an APB master on core_clk; master reset and media sense are
// asynchronous pins.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "fdpc_cfg.svh"
module fdpc_pin_ctrl
  import fdpc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Master reset pin
  input wire logic masterResetIn,
  // Drive pins
  output logic [1:0] motorEnableN,
  input wire logic [1:0] mediaSenseIn,
  output logic [1:0] dataRateOut,
  output logic [1:0] dataRateOe,
  output logic [1:0] mediaPullupEn
);

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  logic mstRstMeta_r;
  logic mstRstSync_r;
  logic [1:0] senseMeta_r;
  logic [1:0] senseSync_r;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mstRstMeta_r <= 1'b0;
      mstRstSync_r <= 1'b0;
    end else begin
      mstRstMeta_r <= masterResetIn;
      mstRstSync_r <= mstRstMeta_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      senseMeta_r <= 2'h0;
      senseSync_r <= 2'h0;
    end else begin
      senseMeta_r <= mediaSenseIn;
      senseSync_r <= senseMeta_r;
    end
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic [`FDPC_ADDR_W-1:0] addr;
  logic access;
  logic wrEn;
  logic mapped;

  assign addr = paddr[`FDPC_ADDR_W-1:0];
  assign access = psel && penable;
  assign wrEn = access && pwrite;
  assign pready = 1'b1;

  always_comb begin
    case (addr)
      `FDPC_OFS_DIGOUT, `FDPC_OFS_DSR, `FDPC_OFS_CFGCTL, `FDPC_OFS_FNEN,
      `FDPC_OFS_FNCTL, `FDPC_OFS_MODE, `FDPC_OFS_CONF, `FDPC_OFS_LOCK,
      `FDPC_OFS_SPEC, `FDPC_OFS_STAT: mapped = (paddr[31:8] == 24'h0);
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = access && !mapped;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  fdpc_byte_t digOut_r;
  fdpc_byte_t dsr_r;
  fdpc_byte_t cfgCtl_r;
  fdpc_byte_t fnEn_r;
  fdpc_byte_t fnCtl_r;
  fdpc_byte_t mode_r;
  fdpc_byte_t conf_r;
  fdpc_byte_t lock_r;
  fdpc_byte_t spec_r;
  fdpc_ctl_e ctlState_r;
  fdpc_ctl_e ctlState_nxt;

  // Registers that master reset returns to defaults
  always_ff @(posedge core_clk) begin
    if (!resetn || mstRstSync_r) begin
      digOut_r <= `FDPC_DIGOUT_RST;
      dsr_r <= `FDPC_DSR_RST;
      cfgCtl_r <= `FDPC_CFGCTL_RST;
      mode_r <= `FDPC_MODE_RST;
      conf_r <= `FDPC_CONF_RST;
      lock_r <= `FDPC_LOCK_RST;
    end else if (wrEn && mapped) begin
      case (addr)
        `FDPC_OFS_DIGOUT: digOut_r <= pwdata[7:0];
        `FDPC_OFS_DSR: dsr_r <= pwdata[7:0];
        `FDPC_OFS_CFGCTL: cfgCtl_r <= pwdata[7:0];
        `FDPC_OFS_MODE: mode_r <= pwdata[7:0];
        `FDPC_OFS_CONF: conf_r <= pwdata[7:0];
        `FDPC_OFS_LOCK: lock_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Chip configuration registers
  always_ff @(posedge core_clk) begin
    if (!resetn || mstRstSync_r) begin
      fnEn_r <= `FDPC_FNEN_RST;
      fnCtl_r <= `FDPC_FNCTL_RST;
    end else if (wrEn && addr == `FDPC_OFS_FNEN && mapped) begin
      fnEn_r <= pwdata[7:0];
    end else if (wrEn && addr == `FDPC_OFS_FNCTL && mapped) begin
      fnCtl_r <= pwdata[7:0];
    end
  end

  // Specify parameters: only the system reset clears them
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      spec_r <= `FDPC_SPEC_RST;
    end else if (wrEn && addr == `FDPC_OFS_SPEC && mapped) begin
      spec_r <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // Controller state
  // ------------------------------------------------------------
  always_comb begin
    case (ctlState_r)
      FDPC_IDLE: ctlState_nxt = digOut_r[`FDPC_DIGOUT_EN_BIT] ?
                                FDPC_ACTIVE : FDPC_IDLE;
      FDPC_ACTIVE: ctlState_nxt = digOut_r[`FDPC_DIGOUT_EN_BIT] ?
                                  FDPC_ACTIVE : FDPC_IDLE;
      default: ctlState_nxt = FDPC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn || mstRstSync_r) begin
      ctlState_r <= FDPC_IDLE;
    end else begin
      ctlState_r <= ctlState_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  fdpc_byte_t rdByte;

  always_comb begin
    case (addr)
      `FDPC_OFS_DIGOUT: rdByte = digOut_r;
      `FDPC_OFS_DSR: rdByte = dsr_r;
      `FDPC_OFS_CFGCTL: rdByte = cfgCtl_r;
      `FDPC_OFS_FNEN: rdByte = fnEn_r;
      `FDPC_OFS_FNCTL: rdByte = fnCtl_r;
      `FDPC_OFS_MODE: rdByte = mode_r;
      `FDPC_OFS_CONF: rdByte = conf_r;
      `FDPC_OFS_LOCK: rdByte = lock_r;
      `FDPC_OFS_SPEC: rdByte = spec_r;
      `FDPC_OFS_STAT: rdByte = {4'h0, mstRstSync_r, ctlState_r == FDPC_ACTIVE,
                                senseSync_r};
      default: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= mapped ? {24'h0, rdByte} : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // Motor enables
  // ------------------------------------------------------------
  fdpc_motor_if mot ();

  assign mot.motorBits = digOut_r[`FDPC_DIGOUT_MOT_LSB +: 4];
  assign mot.driveSel = digOut_r[`FDPC_DIGOUT_SEL];
  assign mot.fourDrive = fnEn_r[`FDPC_FNEN_FOUR_BIT];
  assign mot.swap = fnCtl_r[`FDPC_FNCTL_SWAP_BIT];

  fdpc_motor_enc u_enc (
    .mot(mot.enc)
  );

  always_ff @(posedge core_clk) begin
    if (!resetn || mstRstSync_r) begin
      motorEnableN <= `FDPC_INACT_N;
    end else begin
      motorEnableN <= ~mot.motorLogic;
    end
  end

  // ------------------------------------------------------------
  // Media sense and data rate pins
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn || mstRstSync_r) begin
      dataRateOut <= `FDPC_RATE_IDLE;
      dataRateOe <= `FDPC_OE_OFF;
      mediaPullupEn <= `FDPC_PULL_ON;
    end else if (fnCtl_r[`FDPC_FNCTL_RATE_BIT]) begin
      dataRateOut <= dsr_r[`FDPC_DSR_RATE];
      dataRateOe <= `FDPC_OE_ON;
      mediaPullupEn <= `FDPC_PULL_OFF;
    end else begin
      dataRateOut <= `FDPC_RATE_IDLE;
      dataRateOe <= `FDPC_OE_OFF;
      mediaPullupEn <= `FDPC_PULL_ON;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  logic specWr;
  assign specWr = wrEn && addr == `FDPC_OFS_SPEC && mapped;

  logic fourSel;
  assign fourSel = digOut_r[`FDPC_DIGOUT_MOT_LSB +
                            digOut_r[`FDPC_DIGOUT_SEL]];

  sequence s_mst_rst_held;
    mstRstSync_r ##1 mstRstSync_r;
  endsequence

  sequence s_rate_mode;
    !mstRstSync_r && fnCtl_r[`FDPC_FNCTL_RATE_BIT];
  endsequence

  property p_mst_rst_outputs;
    @(posedge core_clk) disable iff (!resetn)
    s_mst_rst_held |-> motorEnableN == `FDPC_INACT_N &&
                       dataRateOe == `FDPC_OE_OFF &&
                       dataRateOut == `FDPC_RATE_IDLE &&
                       ctlState_r == FDPC_IDLE;
  endproperty
  a_mst_rst_outputs: assert property (p_mst_rst_outputs)
    else $error("Outputs active during master reset");

  property p_mst_rst_defaults;
    @(posedge core_clk) disable iff (!resetn)
    mstRstSync_r |=> digOut_r == `FDPC_DIGOUT_RST &&
                     dsr_r == `FDPC_DSR_RST &&
                     cfgCtl_r == `FDPC_CFGCTL_RST &&
                     mode_r == `FDPC_MODE_RST && conf_r == `FDPC_CONF_RST &&
                     lock_r == `FDPC_LOCK_RST;
  endproperty
  a_mst_rst_defaults: assert property (p_mst_rst_defaults)
    else $error("Register not at default after master reset");

  property p_spec_kept;
    @(posedge core_clk) disable iff (!resetn)
    mstRstSync_r && !specWr |=> $stable(spec_r);
  endproperty
  a_spec_kept: assert property (p_spec_kept)
    else $error("Specify parameters changed by master reset");

  property p_cfg_defaults;
    @(posedge core_clk) disable iff (!resetn)
    mstRstSync_r |=> fnEn_r == `FDPC_FNEN_RST && fnCtl_r == `FDPC_FNCTL_RST;
  endproperty
  a_cfg_defaults: assert property (p_cfg_defaults)
    else $error("Configuration register not at default");

  property p_motor_plain;
    @(posedge core_clk) disable iff (!resetn)
    !mstRstSync_r && !mot.fourDrive && !mot.swap
      |=> motorEnableN == ~$past(digOut_r[5:4]);
  endproperty
  a_motor_plain: assert property (p_motor_plain)
    else $error("Motor enable does not follow digital output");

  property p_motor_four;
    @(posedge core_clk) disable iff (!resetn)
    !mstRstSync_r && mot.fourDrive && !mot.swap
      |=> motorEnableN == ~{$past(digOut_r[1]), $past(fourSel)};
  endproperty
  a_motor_four: assert property (p_motor_four)
    else $error("Four-drive encoding wrong");

  property p_motor_swap;
    @(posedge core_clk) disable iff (!resetn)
    !mstRstSync_r && !mot.fourDrive && mot.swap
      |=> motorEnableN == ~{$past(digOut_r[4]), $past(digOut_r[5])};
  endproperty
  a_motor_swap: assert property (p_motor_swap)
    else $error("Motor swap not applied");

  property p_sense_in;
    @(posedge core_clk) disable iff (!resetn)
    !fnCtl_r[`FDPC_FNCTL_RATE_BIT] |=> dataRateOe == `FDPC_OE_OFF &&
                                       mediaPullupEn == `FDPC_PULL_ON;
  endproperty
  a_sense_in: assert property (p_sense_in)
    else $error("Media sense pins not inputs with pull-ups");

  property p_rate_out;
    @(posedge core_clk) disable iff (!resetn)
    s_rate_mode |=> dataRateOe == `FDPC_OE_ON &&
                    mediaPullupEn == `FDPC_PULL_OFF &&
                    dataRateOut == $past(dsr_r[`FDPC_DSR_RATE]);
  endproperty
  a_rate_out: assert property (p_rate_out)
    else $error("Data rate outputs not driven");

endmodule : fdpc_pin_ctrl

// File: fdpc_pkg.sv
// Types of the floppy drive pin control block.
// Assumes fdpc_cfg.svh for all numeric constants.
package fdpc_pkg;
  typedef logic [7:0] fdpc_byte_t;
  typedef enum logic {FDPC_IDLE, FDPC_ACTIVE} fdpc_ctl_e;
endpackage : fdpc_pkg

// File: tb_top.sv
// Testbench of the floppy drive pin control block.
// Assumes fdpc_cfg.svh offsets and an APB slave with pready.
`timescale 1ns/1ns
`include "fdpc_cfg.svh"
module tb_top;
  logic core_clk = 1'b0, resetn = 1'b0, masterResetIn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er;
  logic [1:0] motorEnableN, mediaSenseIn, dataRateOut, dataRateOe;
  logic [1:0] mediaPullupEn, senseDrv = 2'h1, senseVal = 2'h0;
  int err_total = 0, samples_checked = 0, cyc = 0;
  fdpc_pin_ctrl u_fdpc_pin_ctrl (.core_clk(core_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .masterResetIn(masterResetIn), .motorEnableN(motorEnableN),
    .mediaSenseIn(mediaSenseIn), .dataRateOut(dataRateOut),
    .dataRateOe(dataRateOe), .mediaPullupEn(mediaPullupEn));
  fdpc_drive_model u_fdpc_drive_model (.motorEnableN(motorEnableN),
    .dataRateOut(dataRateOut), .dataRateOe(dataRateOe),
    .mediaPullupEn(mediaPullupEn), .senseDrv(senseDrv),
    .senseVal(senseVal), .mediaSenseIn(mediaSenseIn), .motorSpin());
  always #2 core_clk = ~core_clk;
  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task complete_run;
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask : rdchk
  task settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_defaults;
    rdchk(`FDPC_OFS_DIGOUT, `FDPC_DIGOUT_RST);
    rdchk(`FDPC_OFS_DSR, `FDPC_DSR_RST);
    rdchk(`FDPC_OFS_CFGCTL, `FDPC_CFGCTL_RST);
    rdchk(`FDPC_OFS_MODE, `FDPC_MODE_RST);
    rdchk(`FDPC_OFS_CONF, `FDPC_CONF_RST);
    rdchk(`FDPC_OFS_LOCK, `FDPC_LOCK_RST);
    rdchk(`FDPC_OFS_FNEN, `FDPC_FNEN_RST);
    rdchk(`FDPC_OFS_FNCTL, `FDPC_FNCTL_RST);
  endtask : t_defaults
  task t_unmapped;
    apb(1'b1, 8'h28, 32'h0000_00ff);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h28, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask : t_unmapped
  task t_motor;
    for (int m = 0; m < 4; m++) begin
      wr(`FDPC_OFS_DIGOUT, {2'h0, m[1:0], 4'h4});
      settle();
      chk({30'h0, motorEnableN}, {30'h0, ~m[1:0]});
    end
  endtask : t_motor
  task t_four;
    logic [7:0] d;
    wr(`FDPC_OFS_FNEN, 8'h10);
    for (int s = 0; s < 8; s++) begin
      d = {4'h0, 2'h1, s[1:0]};
      if (s[2]) d[4 + s[1:0]] = 1'b1;
      wr(`FDPC_OFS_DIGOUT, d);
      settle();
      chk({30'h0, motorEnableN}, {30'h0, ~{s[1], s[2]}});
    end
    wr(`FDPC_OFS_FNEN, 8'h00);
  endtask : t_four
  task t_swap;
    wr(`FDPC_OFS_FNCTL, 8'h10);
    wr(`FDPC_OFS_DIGOUT, 8'h14);
    settle();
    chk({30'h0, motorEnableN}, 32'h1);
    wr(`FDPC_OFS_FNCTL, 8'h00);
    settle();
    chk({30'h0, motorEnableN}, 32'h2);
  endtask : t_swap
  task t_sense;
    wr(`FDPC_OFS_DSR, 8'h03);
    settle();
    chk({28'h0, dataRateOe, mediaPullupEn}, 32'h3);
    repeat (3) @(posedge core_clk);
    apb(1'b0, `FDPC_OFS_STAT, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h2);
    wr(`FDPC_OFS_FNCTL, 8'h01);
    settle();
    chk({26'h0, dataRateOe, dataRateOut, mediaPullupEn}, 32'h3c);
    wr(`FDPC_OFS_DSR, 8'h02);
    settle();
    chk({30'h0, dataRateOut}, 32'h2);
  endtask : t_sense
  task t_master_reset;
    wr(`FDPC_OFS_DIGOUT, 8'h34);
    wr(`FDPC_OFS_DSR, 8'h01);
    wr(`FDPC_OFS_CFGCTL, 8'h00);
    wr(`FDPC_OFS_FNEN, 8'h10);
    wr(`FDPC_OFS_FNCTL, 8'h11);
    wr(`FDPC_OFS_MODE, 8'h05);
    wr(`FDPC_OFS_CONF, 8'h06);
    wr(`FDPC_OFS_LOCK, 8'h07);
    wr(`FDPC_OFS_SPEC, 8'h5a);
    @(posedge core_clk);
    masterResetIn <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    chk({26'h0, motorEnableN, dataRateOe, mediaPullupEn}, 32'h33);
    apb(1'b0, `FDPC_OFS_STAT, 32'h0);
    chk({28'h0, rd[3:2]}, 32'h2);
    masterResetIn <= 1'b0;
    repeat (5) @(posedge core_clk);
    t_defaults();
    rdchk(`FDPC_OFS_SPEC, 8'h5a);
    chk({30'h0, motorEnableN}, 32'h3);
  endtask : t_master_reset
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    chk({26'h0, motorEnableN, dataRateOe, mediaPullupEn}, 32'h33);
    t_defaults();
    t_unmapped();
    t_motor();
    t_four();
    t_swap();
    t_sense();
    t_master_reset();
    complete_run();
  end
endmodule : tb_top
